// ---- rtl/cpes_top.v ----
// How it works
// - Event 14H/01H counts every cycle the divider is busy, integer or float.
// - Divider event with edge and threshold one counts divide operations.
// - Event 24H/01H counts demand data reads hitting second level.
// - Event 24H/03H counts demand and first-level prefetch data loads to second level.
// - Event 24H ownership stores: 04H hits, 08H misses, 0CH all.
// - Event 24H instruction fetches: 10H hits, 20H misses, 30H all.
// - Event 24H prefetcher requests: 40H hits, 80H misses, C0H all.
// - Event 27H locked stores: 01H misses, 08H modified hits, 0FH all.
// - Event 28H writebacks: 01H LLC misses, 04H exclusive, 08H modified, 0FH all.
// - Event 2EH/4FH counts core requests referencing last-level cache.
// - Event 2EH/41H counts each last-level cache miss.
// - Event 3CH/00H counts core cycles while thread not halted.
// - Event 3CH/01H counts 100 MHz reference ticks while not halted.
// - Event 48H/01H adds outstanding misses each cycle, counter two only.
// - Outstanding misses: threshold one counts cycles, plus edge counts occurrences.
`include "cpes_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module cpes_top
#(
    parameter COUNTER_INDEX = 2,
    parameter CNT_W = 48,
    parameter PEND_W = 4
)
(
    input wire clock,
    input wire sys_rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire divider_busy,
    input wire l2_demand_read_hit,
    input wire l2_demand_read_miss,
    input wire l2_l1_prefetch_read,
    input wire l2_ownership_hit,
    input wire l2_ownership_miss,
    input wire l2_fetch_hit,
    input wire l2_fetch_miss,
    input wire l2_prefetch_hit,
    input wire l2_prefetch_miss,
    input wire locked_store_miss,
    input wire locked_store_shared_hit,
    input wire locked_store_exclusive_hit,
    input wire locked_store_modified_hit,
    input wire writeback_llc_miss,
    input wire writeback_shared_hit,
    input wire writeback_exclusive_hit,
    input wire writeback_modified_hit,
    input wire llc_reference,
    input wire llc_miss,
    input wire thread_halted,
    input wire fixed_reference_clock,
    input wire [PEND_W-1:0] outstanding_l1d_misses,
    output reg [CNT_W-1:0] count_out,
    output reg select_valid
);
    localparam [PEND_W-1:0] ONE_INC = {{(PEND_W-1){1'b0}}, 1'b1};
    localparam [PEND_W-1:0] ZERO_INC = {PEND_W{1'b0}};
    localparam [1:0] MY_INDEX = COUNTER_INDEX[1:0];
    // A divided phase must outlast three core cycles to get through the
    // synchroniser, so each seen toggle stands for a batch of reference ticks.
    localparam [PEND_W-1:0] REF_TICKS = `CPES_REF_DIV;
    reg [31:0] sel_reg;
    reg [CNT_W-1:0] cnt_reg;
    reg [CNT_W-1:0] cnt_next;
    reg [PEND_W-1:0] raw_inc;
    reg hit_valid;
    reg ref_phase_reg;
    reg [2:0] ref_div_reg;
    wire ref_toggle;
    wire [PEND_W-1:0] qual_inc;
    wire [7:0] ev_code;
    wire [7:0] um_code;
    wire [7:0] thr;
    wire edge_en;
    wire cnt_en;
    wire wb_req;
    wire wr_sel;
    wire wr_lo;
    wire wr_hi;
    wire rd_req;
    assign ev_code = sel_reg[`CPES_SEL_EVT_LSB+7:`CPES_SEL_EVT_LSB];
    assign um_code = sel_reg[`CPES_SEL_UM_LSB+7:`CPES_SEL_UM_LSB];
    assign thr = sel_reg[`CPES_SEL_THR_LSB+7:`CPES_SEL_THR_LSB];
    assign edge_en = sel_reg[`CPES_SEL_EDGE_BIT];
    assign cnt_en = sel_reg[`CPES_SEL_EN_BIT];
    // Ack low gates the request, so a held request acts only every second cycle
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_sel = wb_req & wb_we_i & (wb_adr_i == `CPES_ADR_SEL);
    assign wr_lo = wb_req & wb_we_i & (wb_adr_i == `CPES_ADR_CNT_LO);
    assign wr_hi = wb_req & wb_we_i & (wb_adr_i == `CPES_ADR_CNT_HI);
    assign rd_req = wb_req & ~wb_we_i;

    // Divided reference clock, so a toggle always lasts several core cycles
    always @(posedge fixed_reference_clock)
    begin
        ref_div_reg <= ref_div_reg + 3'h1;
        if (ref_div_reg == `CPES_REF_LAST)
        begin
            ref_phase_reg <= ~ref_phase_reg;
        end
    end
    initial ref_div_reg = 3'h0;
    initial ref_phase_reg = 1'b0;

    cpes_sync3 u_ref_sync
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(ref_phase_reg),
        .toggled(ref_toggle)
    );

    // Event select decode
    always @*
    begin
        raw_inc = ZERO_INC;
        hit_valid = 1'b1;
        case (ev_code)
            `CPES_EV_DIV:
            begin
                if (um_code == `CPES_UM_01)
                begin
                    raw_inc = divider_busy ? ONE_INC : ZERO_INC;
                end
                else
                begin
                    hit_valid = 1'b0;
                end
            end
            `CPES_EV_L2REQ:
            begin
                case (um_code)
                    `CPES_UM_01: raw_inc = {{(PEND_W-1){1'b0}}, l2_demand_read_hit};
                    `CPES_UM_03: raw_inc = {{(PEND_W-1){1'b0}},
                        l2_demand_read_hit | l2_demand_read_miss | l2_l1_prefetch_read};
                    `CPES_UM_04: raw_inc = {{(PEND_W-1){1'b0}}, l2_ownership_hit};
                    `CPES_UM_08: raw_inc = {{(PEND_W-1){1'b0}}, l2_ownership_miss};
                    `CPES_UM_0C: raw_inc = {{(PEND_W-1){1'b0}},
                        l2_ownership_hit | l2_ownership_miss};
                    `CPES_UM_10: raw_inc = {{(PEND_W-1){1'b0}}, l2_fetch_hit};
                    `CPES_UM_20: raw_inc = {{(PEND_W-1){1'b0}}, l2_fetch_miss};
                    `CPES_UM_30: raw_inc = {{(PEND_W-1){1'b0}},
                        l2_fetch_hit | l2_fetch_miss};
                    `CPES_UM_40: raw_inc = {{(PEND_W-1){1'b0}}, l2_prefetch_hit};
                    `CPES_UM_80: raw_inc = {{(PEND_W-1){1'b0}}, l2_prefetch_miss};
                    `CPES_UM_C0: raw_inc = {{(PEND_W-1){1'b0}},
                        l2_prefetch_hit | l2_prefetch_miss};
                    default: hit_valid = 1'b0;
                endcase
            end
            `CPES_EV_LOCK:
            begin
                case (um_code)
                    `CPES_UM_01: raw_inc = {{(PEND_W-1){1'b0}}, locked_store_miss};
                    `CPES_UM_08: raw_inc = {{(PEND_W-1){1'b0}},
                        locked_store_modified_hit};
                    `CPES_UM_0F: raw_inc = {{(PEND_W-1){1'b0}},
                        locked_store_miss | locked_store_shared_hit |
                        locked_store_exclusive_hit | locked_store_modified_hit};
                    default: hit_valid = 1'b0;
                endcase
            end
            `CPES_EV_WB:
            begin
                case (um_code)
                    `CPES_UM_01: raw_inc = {{(PEND_W-1){1'b0}}, writeback_llc_miss};
                    `CPES_UM_04: raw_inc = {{(PEND_W-1){1'b0}},
                        writeback_exclusive_hit};
                    `CPES_UM_08: raw_inc = {{(PEND_W-1){1'b0}},
                        writeback_modified_hit};
                    `CPES_UM_0F: raw_inc = {{(PEND_W-1){1'b0}},
                        writeback_llc_miss | writeback_shared_hit |
                        writeback_exclusive_hit | writeback_modified_hit};
                    default: hit_valid = 1'b0;
                endcase
            end
            `CPES_EV_LLC:
            begin
                case (um_code)
                    `CPES_UM_4F: raw_inc = {{(PEND_W-1){1'b0}}, llc_reference};
                    `CPES_UM_41: raw_inc = {{(PEND_W-1){1'b0}}, llc_miss};
                    default: hit_valid = 1'b0;
                endcase
            end
            `CPES_EV_CLK:
            begin
                case (um_code)
                    `CPES_UM_00: raw_inc = {{(PEND_W-1){1'b0}}, ~thread_halted};
                    `CPES_UM_01: raw_inc = (ref_toggle & ~thread_halted) ?
                        REF_TICKS : ZERO_INC;
                    default: hit_valid = 1'b0;
                endcase
            end
            `CPES_EV_PEND:
            begin
                // Other counters lack the miss-occupancy wiring
                if ((um_code == `CPES_UM_01) && (MY_INDEX == `CPES_PEND_COUNTER))
                begin
                    raw_inc = outstanding_l1d_misses;
                end
                else
                begin
                    hit_valid = 1'b0;
                end
            end
            default:
            begin
                hit_valid = 1'b0;
            end
        endcase
    end

    // Threshold and edge turn per-cycle counts into cycles or occurrences
    cpes_qualify #(.INC_W(PEND_W)) u_qualify
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .raw_inc(raw_inc),
        .threshold(thr),
        .edge_en(edge_en),
        .inc(qual_inc)
    );

    // Software counter writes override the same-cycle increment in the half they write
    always @*
    begin
        cnt_next = cnt_reg;
        if (cnt_en && hit_valid)
        begin
            cnt_next = cnt_reg + {{(CNT_W-PEND_W){1'b0}}, qual_inc};
        end
        if (wr_lo)
        begin
            cnt_next = {cnt_next[CNT_W-1:32], wb_dat_i};
        end
        if (wr_hi)
        begin
            cnt_next = {wb_dat_i[CNT_W-33:0], cnt_next[31:0]};
        end
    end

    // Select word; cleared by reset, so counting starts disabled
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            sel_reg <= `CPES_SEL_RESET;
        end
        else if (wr_sel)
        begin
            sel_reg <= wb_dat_i;
        end
    end

    // Counter and its registered copies for the outputs
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            cnt_reg <= {CNT_W{1'b0}};
            count_out <= {CNT_W{1'b0}};
            select_valid <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            count_out <= cnt_next;
            select_valid <= hit_valid;
        end
    end

    // Read data stands only with the acknowledge, zero otherwise
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (rd_req)
            begin
                case (wb_adr_i)
                    `CPES_ADR_SEL: wb_dat_o <= sel_reg;
                    `CPES_ADR_CNT_LO: wb_dat_o <= cnt_reg[31:0];
                    `CPES_ADR_CNT_HI: wb_dat_o <= {{(64-CNT_W){1'b0}}, cnt_reg[CNT_W-1:32]};
                    `CPES_ADR_STAT: wb_dat_o <= {31'h0000_0000, hit_valid};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cpes_defines.vh ----
`ifndef CPES_DEFINES_VH
`define CPES_DEFINES_VH
// Event codes
`define CPES_EV_DIV 8'h14
`define CPES_EV_L2REQ 8'h24
`define CPES_EV_LOCK 8'h27
`define CPES_EV_WB 8'h28
`define CPES_EV_LLC 8'h2e
`define CPES_EV_CLK 8'h3c
`define CPES_EV_PEND 8'h48
// Sub-event codes
`define CPES_UM_00 8'h00
`define CPES_UM_01 8'h01
`define CPES_UM_03 8'h03
`define CPES_UM_04 8'h04
`define CPES_UM_08 8'h08
`define CPES_UM_0C 8'h0c
`define CPES_UM_0F 8'h0f
`define CPES_UM_10 8'h10
`define CPES_UM_20 8'h20
`define CPES_UM_30 8'h30
`define CPES_UM_40 8'h40
`define CPES_UM_41 8'h41
`define CPES_UM_4F 8'h4f
`define CPES_UM_80 8'h80
`define CPES_UM_C0 8'hc0
// Counter index that may count outstanding misses
`define CPES_PEND_COUNTER 2'h2
// Wishbone register byte offsets
`define CPES_ADR_SEL 4'h0
`define CPES_ADR_CNT_LO 4'h4
`define CPES_ADR_CNT_HI 4'h8
`define CPES_ADR_STAT 4'hc
// Select register fields
`define CPES_SEL_EVT_LSB 0
`define CPES_SEL_UM_LSB 8
`define CPES_SEL_EDGE_BIT 16
`define CPES_SEL_EN_BIT 17
`define CPES_SEL_THR_LSB 24
`define CPES_SEL_RESET 32'h0000_0000
// Reference clock 100 MHz, core clock 40 MHz
`define CPES_REF_MHZ 100
`define CPES_CLK_MHZ 40
// Reference edges per phase toggle, and the divider's last count
`define CPES_REF_DIV 4'h8
`define CPES_REF_LAST 3'h7
`endif

// ---- rtl/cpes_sync3.v ----
`timescale 1ns/100ps
`default_nettype none
module cpes_sync3
(
    input wire clock,
    input wire sys_rst,
    input wire din,
    output reg toggled
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg lvl_reg;
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            lvl_reg <= 1'b0;
            toggled <= 1'b0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Change counts once second and third stages agree
            if (s2_reg == s3_reg)
            begin
                lvl_reg <= s3_reg;
            end
            toggled <= (s2_reg == s3_reg) && (s3_reg != lvl_reg) ? 1'b1 : 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/cpes_qualify.v ----
`timescale 1ns/100ps
`default_nettype none
module cpes_qualify
#(
    parameter INC_W = 4
)
(
    input wire clock,
    input wire sys_rst,
    input wire [INC_W-1:0] raw_inc,
    input wire [7:0] threshold,
    input wire edge_en,
    output reg [INC_W-1:0] inc
);
    reg cond_reg;
    wire cond_now;
    assign cond_now = ({{(8 > INC_W ? 8 - INC_W : 0){1'b0}}, raw_inc} >= threshold);
    always @(posedge clock)
    begin
        if (sys_rst)
            cond_reg <= 1'b0;
        else
            cond_reg <= cond_now;
    end
    always @*
    begin
        if (threshold == 8'h00)
            inc = raw_inc;
        else if (edge_en)
            inc = {{(INC_W-1){1'b0}}, cond_now & ~cond_reg};
        else
            inc = {{(INC_W-1){1'b0}}, cond_now};
    end
endmodule
`default_nettype wire

// ---- tb/cpes_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module cpes_top_sva
#(
    parameter CNT_W = 48,
    parameter PEND_W = 4
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic divider_busy,
    input wire logic thread_halted,
    input wire logic [PEND_W-1:0] outstanding_l1d_misses,
    input wire logic [CNT_W-1:0] count_out,
    input wire logic select_valid
);
    logic [31:0] sel_sh;
    logic wbw;
    assign wbw = wb_cyc_i && wb_stb_i && wb_we_i;
    // Shadow select word, taken at the acknowledged write only
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            sel_sh <= 32'h0;
        else if (wbw && wb_ack_o && wb_adr_i == 4'h0)
            sel_sh <= wb_dat_i;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("acknowledge late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("acknowledge without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside acknowledge");
    a_div_count: assert property (sel_sh == 32'h0002_0114 && divider_busy && !wbw |=>
        count_out == $past(count_out) + 1) else $error("busy cycle not counted");
    a_halt_hold: assert property (sel_sh == 32'h0002_003c && thread_halted && !wbw |=>
        $stable(count_out)) else $error("halted cycle counted");
    a_pend_sum: assert property (sel_sh == 32'h0002_0148 && !wbw |=>
        count_out == $past(count_out) + $past(outstanding_l1d_misses))
        else $error("pending misses not added");
    a_sel_valid: assert property (sel_sh == 32'h0002_0114 && $past(sel_sh) == sel_sh
        |-> select_valid) else $error("supported select not flagged");
endmodule
bind cpes_top cpes_top_sva #(.CNT_W(CNT_W), .PEND_W(PEND_W)) i_sva
(
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .divider_busy(divider_busy), .thread_halted(thread_halted),
    .outstanding_l1d_misses(outstanding_l1d_misses), .count_out(count_out),
    .select_valid(select_valid)
);
`default_nettype wire

// ---- tb/cpes_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module cpes_core_model
(
    input wire logic clock,
    input wire logic [18:0] ev_req,
    input wire logic div_req,
    input wire logic halt_req,
    input wire logic [3:0] pend_req,
    output logic [18:0] ev_line,
    output logic div_busy,
    output logic halted,
    output logic [3:0] pend,
    output logic ref_clk
);
    // Sources change only on core edges, as pipeline flops would
    always @(posedge clock)
    begin
        ev_line <= ev_req;
        div_busy <= div_req;
        halted <= halt_req;
        pend <= pend_req;
    end
    // Reference runs free, unrelated in phase to the core clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
endmodule
`default_nettype wire

// ---- tb/cpes_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cpes_defines.vh"
module cpes_top_tb;
    localparam logic [23:0] EV_TAB [20] = '{24'h240101, 24'h240303, 24'h240401, 24'h240801,
        24'h240c02, 24'h241001, 24'h242001, 24'h243002, 24'h244001, 24'h248001, 24'h24c002,
        24'h270101, 24'h270801, 24'h270f04, 24'h280101, 24'h280401, 24'h280801, 24'h280f04,
        24'h2e4f01, 24'h2e4101};
    localparam logic [5:0] DIV_PAT = 6'b101110;
    localparam logic [5:0] HALT_PAT = 6'b001001;
    localparam logic [3:0] PEND_PAT [6] = '{4'h3, 4'h0, 4'h2, 4'h2, 4'h0, 4'h1};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_wd = 32'h0;
    logic [31:0] wb_rd;
    logic wb_ack;
    logic [18:0] ev_req = 19'h0;
    logic div_req = 1'b0;
    logic halt_req = 1'b1;
    logic [3:0] pend_req = 4'h0;
    logic [18:0] ev;
    logic div_busy;
    logic halted;
    logic [3:0] pend;
    logic ref_clk;
    logic [47:0] count_out;
    logic sel_ok;
    int num_errors = 0;
    int checks_done = 0;
    always #12.5 clock = ~clock;
    cpes_core_model i_model
    (
        .clock(clock), .ev_req(ev_req), .div_req(div_req), .halt_req(halt_req),
        .pend_req(pend_req), .ev_line(ev), .div_busy(div_busy), .halted(halted),
        .pend(pend), .ref_clk(ref_clk)
    );
    cpes_top i_dut
    (
        .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wd),
        .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .divider_busy(div_busy),
        .l2_demand_read_hit(ev[0]), .l2_demand_read_miss(ev[1]), .l2_l1_prefetch_read(ev[2]),
        .l2_ownership_hit(ev[3]), .l2_ownership_miss(ev[4]), .l2_fetch_hit(ev[5]),
        .l2_fetch_miss(ev[6]), .l2_prefetch_hit(ev[7]), .l2_prefetch_miss(ev[8]),
        .locked_store_miss(ev[9]), .locked_store_shared_hit(ev[10]),
        .locked_store_exclusive_hit(ev[11]), .locked_store_modified_hit(ev[12]),
        .writeback_llc_miss(ev[13]), .writeback_shared_hit(ev[14]),
        .writeback_exclusive_hit(ev[15]), .writeback_modified_hit(ev[16]),
        .llc_reference(ev[17]), .llc_miss(ev[18]), .thread_halted(halted),
        .fixed_reference_clock(ref_clk), .outstanding_l1d_misses(pend),
        .count_out(count_out), .select_valid(sel_ok)
    );
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [47:0] got, input logic [47:0] lo, input logic [47:0] hi);
        checks_done++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            num_errors++;
            $display("ERROR %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // One classic cycle; entered just after an edge, ends one idle cycle later
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wd <= d;
        @(posedge clock);
        while (wb_ack !== 1'b1)
        begin
            if (n++ > 20)
            begin
                num_errors++;
                $display("ERROR %0t: no acknowledge", $time);
                complete_run;
            end
            @(posedge clock);
        end
        q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic arm(input logic [31:0] s);
        logic [31:0] q;
        wb(1'b1, `CPES_ADR_CNT_LO, 32'h0, q);
        wb(1'b1, `CPES_ADR_CNT_HI, 32'h0, q);
        wb(1'b1, `CPES_ADR_SEL, s, q);
    endtask
    task automatic stop_read(output logic [47:0] c);
        logic [31:0] lo;
        logic [31:0] hi;
        repeat (3) @(posedge clock);
        wb(1'b1, `CPES_ADR_SEL, 32'h0, lo);
        wb(1'b0, `CPES_ADR_CNT_LO, 32'h0, lo);
        wb(1'b0, `CPES_ADR_CNT_HI, 32'h0, hi);
        c = {hi[15:0], lo};
    endtask
    // All three sources move together; the select picks which one counts
    task automatic burst(input logic [31:0] s, input logic [47:0] e);
        logic [47:0] c;
        arm(s);
        for (int i = 0; i < 6; i++)
        begin
            div_req <= DIV_PAT[i];
            pend_req <= PEND_PAT[i];
            halt_req <= HALT_PAT[i];
            @(posedge clock);
        end
        div_req <= 1'b0;
        pend_req <= 4'h0;
        halt_req <= 1'b1;
        stop_read(c);
        chk(c, e);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        wb(1'b0, `CPES_ADR_SEL, 32'h0, q);
        chk(q, `CPES_SEL_RESET);
        wb(1'b1, `CPES_ADR_CNT_HI, 32'hffff_ffff, q);
        wb(1'b0, `CPES_ADR_CNT_HI, 32'h0, q);
        chk(q, 48'h0000_ffff);
        wb(1'b0, 4'h2, 32'h0, q);
        chk(q, 48'h0);
        wb(1'b1, `CPES_ADR_SEL, 32'h0002_0214, q);
        wb(1'b0, `CPES_ADR_STAT, 32'h0, q);
        chk(q[0], 1'b0);
        $display("Test registers done");
    endtask
    task automatic t_events;
        logic [47:0] c;
        logic [31:0] q;
        for (int k = 0; k < 20; k++)
        begin
            arm({16'h0002, EV_TAB[k][15:8], EV_TAB[k][23:16]});
            wb(1'b0, `CPES_ADR_STAT, 32'h0, q);
            chk(q[0], 1'b1);
            for (int i = 0; i < 19; i++)
            begin
                ev_req <= 19'h1 << i;
                @(posedge clock);
            end
            ev_req <= 19'h0;
            stop_read(c);
            chk(c, EV_TAB[k][7:0]);
        end
        $display("Test cache events done");
    endtask
    task automatic t_div;
        burst(32'h0002_0114, 48'd4);
        burst(32'h0103_0114, 48'd2);
        burst(32'h0202_0114, 48'd0);
        $display("Test divider done");
    endtask
    task automatic t_pend;
        burst(32'h0002_0148, 48'd8);
        burst(32'h0102_0148, 48'd4);
        burst(32'h0103_0148, 48'd3);
        burst(32'h0202_0148, 48'd3);
        burst(32'h0203_0148, 48'd2);
        $display("Test pending misses done");
    endtask
    task automatic t_halt;
        logic [47:0] c;
        burst(32'h0002_003c, 48'd4);
        arm(32'h0002_013c);
        halt_req <= 1'b0;
        repeat (40) @(posedge clock);
        halt_req <= 1'b1;
        stop_read(c);
        chk_rng(c, 48'd88, 48'd108);
        $display("Test unhalted done");
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_regs;
        t_events;
        t_div;
        t_pend;
        t_halt;
        complete_run;
    end
endmodule
`default_nettype wire
